// >>> design/power_mode_unit.sv
// power mode manager: four modes, control via register port
module power_mode_unit (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic              wait_exec,
  input  wire logic              irq_taken,
  input  wire logic              wake_event,
  input  wire logic              slow_clock_stable,
  input  wire logic              fast_clock_stable,
  input  wire logic              mode_stall,
  output pmu_pkg::pmu_mode_e     mode,
  output pmu_pkg::pmu_gates_s    gates,
  output pmu_pkg::pmu_status_s   status
);
  import pmu_pkg::*;

  localparam logic [2:0] PMU_ADDR_CTRL = 3'h0;

  logic      save_req_q, save_req_d;
  logic      save_pend_q, save_pend_d;
  logic      fosc_off_q, fosc_off_d;
  logic      idle_q, idle_d;
  logic      halt_q, halt_d;
  logic      defer_q, defer_d;
  logic      waiting_q, waiting_d;
  logic      wait_pend_q, wait_pend_d;
  pmu_mode_e mode_q, mode_d;
  logic [7:0] rdata_q;
  logic      slow_ok;
  logic      fast_ok;
  logic      wake_s;

  pmu_sync u_sync_slow (
    .mclk (mclk),
    .rst  (rst),
    .din  (slow_clock_stable),
    .dout (slow_ok)
  );
  pmu_sync u_sync_fast (
    .mclk (mclk),
    .rst  (rst),
    .din  (fast_clock_stable),
    .dout (fast_ok)
  );
  pmu_sync u_sync_wake (
    .mclk (mclk),
    .rst  (rst),
    .din  (wake_event),
    .dout (wake_s)
  );

  // register decode
  wire ctrl_wr = reg_wr && (reg_addr == PMU_ADDR_CTRL);
  wire ctrl_rd = reg_rd && (reg_addr == PMU_ADDR_CTRL);
  // stall may be tied low at top level; logic still honours it
  wire stalled = mode_stall;
  // wait seen now or held from an earlier stalled cycle
  wire wait_now = wait_exec | wait_pend_q;

  wire in_act = (mode_q == PMU_ACTIVE);
  wire in_save = (mode_q == PMU_SAVE);

  wire want_save = save_pend_q && in_act && (!defer_q || wait_now);
  // idle/halt need wait and defer from active
  wire want_idle = idle_q && wait_now && (!in_act || defer_q) && (in_act || in_save);
  wire want_halt = halt_q && wait_now && (!in_act || defer_q) && (mode_q != PMU_HALT);
  wire slow_gate = slow_ok || !in_act;

  // next mode and control bits
  always_comb begin
    mode_d      = mode_q;
    save_req_d  = save_req_q;
    save_pend_d = save_pend_q;
    fosc_off_d  = fosc_off_q;
    idle_d      = idle_q;
    halt_d      = halt_q;
    defer_d     = defer_q;
    waiting_d   = waiting_q;
    wait_pend_d = wait_pend_q;
    if (ctrl_wr) begin
      fosc_off_d = reg_wdata[PMU_BIT_FOSC_OFF];
      idle_d  = reg_wdata[PMU_BIT_IDLE];
      halt_d  = reg_wdata[PMU_BIT_HALT];
      defer_d = reg_wdata[PMU_BIT_DEFER];
      save_pend_d = reg_wdata[PMU_BIT_SAVE];
      // deferred request shows set at once; immediate only once done
      save_req_d  = reg_wdata[PMU_BIT_SAVE] & (reg_wdata[PMU_BIT_DEFER] | !in_act);
    end
    // cpu stalls on wait until interrupt
    // a wait in the same cycle as an ack wins, so the core is not left running
    if (irq_taken) begin
      waiting_d = 1'b0;
    end
    if (wait_exec) begin
      waiting_d = 1'b1;
    end
    if (stalled) begin
      wait_pend_d = wait_pend_q | wait_exec;
    end else begin
      wait_pend_d = 1'b0;
      // mode changes only while not stalled
      if (wake_s && !in_act && fast_ok) begin
        // wake-up clears bits, back to active
        mode_d      = PMU_ACTIVE;
        save_req_d  = 1'b0;
        save_pend_d = 1'b0;
        fosc_off_d  = 1'b0;
        idle_d      = 1'b0;
        halt_d      = 1'b0;
      end else if (want_halt) begin
        mode_d = PMU_HALT;
      end else if (want_idle && slow_gate) begin
        mode_d = PMU_IDLE;
      end else if (want_save && slow_gate) begin
        mode_d     = PMU_SAVE;
        save_req_d = 1'b1;
      end else if (in_save && !save_pend_q && !idle_q && !halt_q && fast_ok) begin
        // software cleared the save bit: back to active
        mode_d = PMU_ACTIVE;
      end
    end
  end

  // single mode register, active after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q      <= PMU_MODE_RST;
      save_req_q  <= PMU_CTRL_RST[PMU_BIT_SAVE];
      save_pend_q <= 1'b0;
      fosc_off_q  <= PMU_CTRL_RST[PMU_BIT_FOSC_OFF];
      idle_q      <= PMU_CTRL_RST[PMU_BIT_IDLE];
      halt_q      <= PMU_CTRL_RST[PMU_BIT_HALT];
      defer_q     <= PMU_CTRL_RST[PMU_BIT_DEFER];
      waiting_q   <= 1'b0;
      wait_pend_q <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      save_req_q  <= save_req_d;
      save_pend_q <= save_pend_d;
      fosc_off_q  <= fosc_off_d;
      idle_q      <= idle_d;
      halt_q      <= halt_d;
      defer_q     <= defer_d;
      waiting_q   <= waiting_d;
      wait_pend_q <= wait_pend_d;
    end
  end

  // read data one cycle after strobe, zero elsewhere
  wire [7:0] ctrl_view = {fast_ok, slow_ok, defer_q, 1'b0, halt_q, idle_q, fosc_off_q, save_req_q};
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= ctrl_rd ? ctrl_view : 8'h00;
    end
  end

  pmu_gate_map u_gate_map (
    .mclk                 (mclk),
    .rst                  (rst),
    .mode                 (mode_q),
    .fast_osc_disable_bit (fosc_off_q),
    .cpu_waiting          (waiting_q),
    .gates                (gates),
    .status               (status)
  );

  assign mode      = mode_q;
  assign reg_rdata = rdata_q;
endmodule

// >>> pkg/pmu_pkg.sv
// How it works
// - exactly four modes, one at a time
// - reset lands in active mode
// - active: all clocks but slow_clk_en run, timer slow
// - power save: everything runs on slow clock
// - fast osc follows disable bit in save/idle
// - idle: only manager and timer clocked slowly
// - halt: all clocks off, fast osc off
// - halt: slow clock to timer stopped
// - low-rate oscillator always enabled
// - wait in active stalls cpu until interrupt
// - save via wait halts cpu, else runs
// - power-save status high unless active
// - idle status high only in idle
// - halt status high only in halt
// - no mode change while stall asserted
// - stall input may be tied inactive at top level
// - save request immediate or at next wait
// - idle/halt bits enter on wait with defer
// - wake-up clears bits, returns to active
// - save/idle entry from active needs slow clock stable
package pmu_pkg;

  typedef enum logic [1:0] {
    PMU_ACTIVE = 2'h0,
    PMU_SAVE   = 2'h1,
    PMU_IDLE   = 2'h3,
    PMU_HALT   = 2'h2
  } pmu_mode_e;

  typedef struct packed {
    logic power_save;
    logic idle;
    logic halt;
  } pmu_status_s;

  typedef struct packed {
    logic main_clk_en;
    logic slow_clk_en;
    logic timer_clk_en;
    logic pmu_clk_en;
    logic fast_osc_en;
    logic low_osc_en;
    logic cpu_run;
  } pmu_gates_s;

  // control register field positions
  localparam int PMU_BIT_SAVE  = 0;
  localparam int PMU_BIT_FOSC_OFF = 1;
  localparam int PMU_BIT_IDLE  = 2;
  localparam int PMU_BIT_HALT  = 3;
  localparam int PMU_BIT_DEFER = 5;
  localparam int PMU_BIT_SLOW  = 6;
  localparam int PMU_BIT_FAST  = 7;

  localparam logic [7:0] PMU_CTRL_RST = 8'h00;
  localparam pmu_mode_e  PMU_MODE_RST = PMU_ACTIVE;
  localparam logic [1:0] PMU_SYNC_RST = 2'h0;

endpackage

// >>> design/pmu_sync.sv
// three-stage synchroniser; change accepted when stages two and three agree
module pmu_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  import pmu_pkg::*;

  logic       meta_q;
  logic [1:0] pipe_q;
  logic       dout_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'b0;
      pipe_q <= PMU_SYNC_RST;
      dout_q <= 1'b0;
    end else begin
      meta_q <= din;
      pipe_q <= {pipe_q[0], meta_q};
      if (pipe_q[0] == pipe_q[1]) begin
        dout_q <= pipe_q[1];
      end
    end
  end

  assign dout = dout_q;
endmodule

// >>> design/pmu_gate_map.sv
// mode to clock and oscillator gating, registered
module pmu_gate_map (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire pmu_pkg::pmu_mode_e mode,
  input  wire logic              fast_osc_disable_bit,
  input  wire logic              cpu_waiting,
  output pmu_pkg::pmu_gates_s    gates,
  output pmu_pkg::pmu_status_s   status
);
  import pmu_pkg::*;

  pmu_gates_s  gates_d;
  pmu_gates_s  gates_q;
  pmu_status_s status_d;
  pmu_status_s status_q;

  wire in_act  = (mode == PMU_ACTIVE);
  wire in_save = (mode == PMU_SAVE);
  wire in_idle = (mode == PMU_IDLE);
  wire in_halt = (mode == PMU_HALT);

  assign gates_d.main_clk_en  = in_act;
  assign gates_d.slow_clk_en  = in_save;
  assign gates_d.timer_clk_en = !in_halt;
  assign gates_d.pmu_clk_en   = !in_halt;
  assign gates_d.fast_osc_en  = in_act | ((in_save | in_idle) & !fast_osc_disable_bit);
  assign gates_d.low_osc_en   = 1'b1;
  assign gates_d.cpu_run      = (in_act | in_save) & !cpu_waiting;

  assign status_d.power_save = !in_act;
  assign status_d.idle       = in_idle;
  assign status_d.halt       = in_halt;

  // registered so consumers see glitch-free enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      gates_q  <= '{main_clk_en: 1'b1, slow_clk_en: 1'b0, timer_clk_en: 1'b1,
                    pmu_clk_en: 1'b1, fast_osc_en: 1'b1, low_osc_en: 1'b1, cpu_run: 1'b1};
      status_q <= '0;
    end else begin
      gates_q  <= gates_d;
      status_q <= status_d;
    end
  end

  assign gates  = gates_q;
  assign status = status_q;
endmodule

// >>> test/pmu_props.sv
// port-level checks of mode status and clock gating
module pmu_props (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 mode_stall,
  input wire pmu_pkg::pmu_mode_e   mode,
  input wire pmu_pkg::pmu_gates_s  gates,
  input wire pmu_pkg::pmu_status_s status
);
  import pmu_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // gates and status lag mode by one edge; skip the edge after reset
  sequence s_was(pmu_mode_e m);
    !$past(rst) && $past(mode) == m;
  endsequence
  a_save_status: assert property (!$past(rst) |-> status.power_save == ($past(mode) != PMU_ACTIVE))
    else $error("power save status wrong");
  a_idle_status: assert property (!$past(rst) |-> status.idle == ($past(mode) == PMU_IDLE))
    else $error("idle status wrong");
  a_halt_status: assert property (!$past(rst) |-> status.halt == ($past(mode) == PMU_HALT))
    else $error("halt status wrong");
  a_low_osc_on: assert property (gates.low_osc_en)
    else $error("low rate oscillator off");
  a_active_clocks: assert property (s_was(PMU_ACTIVE) |-> gates.main_clk_en && gates.timer_clk_en && gates.fast_osc_en)
    else $error("active gating wrong");
  a_save_clocks: assert property (s_was(PMU_SAVE) |-> !gates.main_clk_en && gates.slow_clk_en)
    else $error("save gating wrong");
  a_idle_clocks: assert property (s_was(PMU_IDLE) |-> !gates.main_clk_en && gates.timer_clk_en && gates.pmu_clk_en)
    else $error("idle gating wrong");
  a_halt_clocks: assert property (s_was(PMU_HALT) |-> !gates.main_clk_en && !gates.timer_clk_en && !gates.fast_osc_en)
    else $error("halt gating wrong");
  a_stall_holds: assert property (mode_stall |=> $stable(mode))
    else $error("mode moved while stalled");
endmodule
bind power_mode_unit pmu_props u_props (.mclk(mclk), .rst(rst), .mode_stall(mode_stall), .mode(mode), .gates(gates),
  .status(status));

// >>> test/pmu_far_model.sv
// cpu and clock sources beside the manager
module pmu_far_model #(parameter int ACK_DLY = 5) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               wake_req,
  input  wire logic               slow_ok,
  input  wire logic               fast_ok,
  input  wire pmu_pkg::pmu_mode_e mode,
  output logic                    wake_event,
  output logic                    irq_taken,
  output logic                    slow_clock_stable,
  output logic                    fast_clock_stable
);
  import pmu_pkg::*;
  logic [3:0] cnt_q;
  assign slow_clock_stable = slow_ok;
  // wake stays latched until acked; ack waits for a clocked core
  // wait ended by ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 4'h0;
      wake_event <= 1'b0;
      irq_taken <= 1'b0;
      fast_clock_stable <= 1'b0;
    end else begin
      fast_clock_stable <= fast_ok;
      irq_taken <= 1'b0;
      if (wake_req) wake_event <= 1'b1;
      if (wake_event && mode == PMU_ACTIVE) cnt_q <= cnt_q + 4'h1;
      if (cnt_q == ACK_DLY[3:0]) begin
        irq_taken <= 1'b1;
        wake_event <= 1'b0;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule

// >>> test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pmu_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        wait_exec = 1'b0;
  logic        mode_stall = 1'b0;
  logic        wake_req = 1'b0;
  logic        slow_ok = 1'b1;
  logic        fast_ok = 1'b1;
  logic [7:0]  reg_rdata;
  logic        irq_taken, wake_event, slow_st, fast_st;
  pmu_mode_e   mode;
  pmu_gates_s  gates;
  pmu_status_s status;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [15:0] lfsr = 16'h968c;
  always #20 mclk = ~mclk;
  power_mode_unit DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_exec(wait_exec), .irq_taken(irq_taken), .wake_event(wake_event),
    .slow_clock_stable(slow_st), .fast_clock_stable(fast_st), .mode_stall(mode_stall), .mode(mode), .gates(gates),
    .status(status));
  pmu_far_model far (.mclk(mclk), .rst(rst), .wake_req(wake_req), .slow_ok(slow_ok), .fast_ok(fast_ok), .mode(mode),
    .wake_event(wake_event), .irq_taken(irq_taken), .slow_clock_stable(slow_st), .fast_clock_stable(fast_st));
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] exp_status(pmu_mode_e m);
    return {5'h00, m != PMU_ACTIVE, m == PMU_IDLE, m == PMU_HALT};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic pulse_wait();
    @(posedge mclk);
    wait_exec <= 1'b1;
    @(posedge mclk);
    wait_exec <= 1'b0;
  endtask
  // bounded wait for the mode, then status one edge later
  task automatic go(input pmu_mode_e m);
    int n;
    n = 0;
    while (n < 40 && mode !== m) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    chk({6'h00, mode}, {6'h00, m});
    chk({5'h00, status}, exp_status(m));
  endtask
  task automatic wake();
    int n;
    n = 0;
    @(posedge mclk);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    go(PMU_ACTIVE);
    // a wake still latched would knock the next low-power entry straight back
    while (n < 40 && wake_event !== 1'b0) begin
      @(posedge mclk);
      n++;
    end
    repeat (6) @(posedge mclk);
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk({6'h00, mode}, 8'h00);
    rd(3'h0, 8'hc0);
    lfsr = lfsr_next(lfsr);
    wr(3'h4, lfsr[7:0]);
    rd(3'h4, 8'h00);
    rd(3'h0, 8'hc0);
    $display("test reset done");
    pulse_wait();
    repeat (3) @(posedge mclk);
    #1;
    chk(gates.cpu_run, 1'b0);
    wake();
    repeat (8) @(posedge mclk);
    #1;
    chk(gates.cpu_run, 1'b1);
    wr(3'h0, 8'h03);
    go(PMU_SAVE);
    chk(gates.cpu_run, 1'b1);
    chk(gates.fast_osc_en, 1'b0);
    rd(3'h0, 8'hc3);
    wake();
    rd(3'h0, 8'hc0);
    wr(3'h0, 8'h21);
    rd(3'h0, 8'he1);
    chk({6'h00, mode}, 8'h00);
    pulse_wait();
    go(PMU_SAVE);
    chk(gates.cpu_run, 1'b0);
    wake();
    $display("test save done");
    for (int i = 0; i < 2; i++) begin
      wr(3'h0, i == 0 ? 8'h28 : 8'h24);
      pulse_wait();
      go(i == 0 ? PMU_HALT : PMU_IDLE);
      wake();
      rd(3'h0, 8'he0);
    end
    wr(3'h0, 8'h00);
    slow_ok <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(3'h0, 8'h01);
    repeat (10) @(posedge mclk);
    #1;
    chk({6'h00, mode}, 8'h00);
    wr(3'h0, 8'h28);
    pulse_wait();
    go(PMU_HALT);
    wake();
    slow_ok <= 1'b1;
    repeat (6) @(posedge mclk);
    $display("test slow clock done");
    wr(3'h0, 8'h24);
    mode_stall <= 1'b1;
    pulse_wait();
    lfsr = lfsr_next(lfsr);
    repeat (4 + int'(lfsr[3:0])) @(posedge mclk);
    #1;
    chk({6'h00, mode}, 8'h00);
    @(posedge mclk);
    mode_stall <= 1'b0;
    go(PMU_IDLE);
    wake();
    $display("test stall done");
    // software exit from save, then wake held off while fast clock unstable
    wr(3'h0, 8'h01);
    go(PMU_SAVE);
    chk(gates.fast_osc_en, 1'b1);
    wr(3'h0, 8'h00);
    go(PMU_ACTIVE);
    wr(3'h0, 8'h01);
    go(PMU_SAVE);
    @(posedge mclk);
    fast_ok <= 1'b0;
    repeat (6) @(posedge mclk);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    chk({6'h00, mode}, 8'h01);
    rd(3'h0, 8'h41);
    @(posedge mclk);
    fast_ok <= 1'b1;
    wake();
    rd(3'h0, 8'hc0);
    $display("test fast clock done");
    test_done();
  end
endmodule
